// File: insn_decode_pkg.sv
// package: instruction word layout, classes, patterns and timing constants
package insn_decode_pkg;
    localparam int WORD_W = 14;
    localparam int FILE_W = 7;
    localparam int BITN_W = 3;
    localparam int LIT8_W = 8;
    localparam int LIT11_W = 11;
    localparam int LIT7_W = 7;
    localparam int LIT5_W = 5;
    localparam int MODE_W = 2;
    localparam int DEST_POS = 7;
    localparam int BITN_LSB = 7;
    localparam int PTR_POS = 2;
    localparam int QUARTERS = 4;
    localparam int OSC_KHZ = 40000;
    localparam int INSN_KHZ = OSC_KHZ / QUARTERS;
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q4 = 2'h3;
    localparam logic [1:0] EXTRA_NONE = 2'h0;
    localparam logic [1:0] EXTRA_ONE = 2'h1;
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [FILE_W-1:0] IND_REG0 = 7'h00;
    localparam logic [FILE_W-1:0] IND_REG1 = 7'h01;
    // opcode patterns and masks; masked-out bits are don't-care
    localparam logic [13:0] M_CTL = 14'h3FFF;
    localparam logic [13:0] P_RET = 14'h0008;
    localparam logic [13:0] P_IRET = 14'h0009;
    localparam logic [13:0] P_CALL_VIA_ACCUMULATOR = 14'h000A;
    localparam logic [13:0] P_ACCBR = 14'h000B;
    localparam logic [13:0] M_IND = 14'h3FF8;
    localparam logic [13:0] P_IND = 14'h0010;
    localparam logic [13:0] M_BANK = 14'h3FE0;
    localparam logic [13:0] P_BANK = 14'h0020;
    localparam logic [13:0] M_GRP = 14'h3F80;
    localparam logic [13:0] P_GRP0 = 14'h0000;
    localparam logic [13:0] M_BYTE = 14'h3F00;
    localparam logic [13:0] P_DECSK = 14'h0B00;
    localparam logic [13:0] P_INCSK = 14'h0F00;
    localparam logic [13:0] M_TOP2 = 14'h3000;
    localparam logic [13:0] P_BYTE = 14'h0000;
    localparam logic [13:0] P_BITG = 14'h1000;
    localparam logic [13:0] M_SKB = 14'h3800;
    localparam logic [13:0] P_SKB = 14'h1800;
    localparam logic [13:0] P_CALL = 14'h2000;
    localparam logic [13:0] P_JUMP = 14'h2800;
    localparam logic [13:0] M_REL = 14'h3E00;
    localparam logic [13:0] P_REL = 14'h3200;
    localparam logic [13:0] P_PCH = 14'h3180;
    localparam logic [13:0] M_RLIT = 14'h3C00;
    localparam logic [13:0] P_RLIT = 14'h3400;
    typedef enum logic [1:0] {
        MODE_PRE_INC = 2'b00,
        MODE_PRE_DEC = 2'b01,
        MODE_POST_INC = 2'b10,
        MODE_POST_DEC = 2'b11
    } ptr_mode_t;
    typedef enum logic [3:0] {
        CL_NOP = 4'h0, CL_BYTE = 4'h1, CL_BIT_OP = 4'h2, CL_SKIP_BIT = 4'h3,
        CL_SKIP_CNT = 4'h4, CL_LITERAL = 4'h5, CL_CALL = 4'h6, CL_JUMP = 4'h7,
        CL_RETURN = 4'h8, CL_RET_LIT = 4'h9, CL_REL_BR = 4'hA, CL_ACC_BR = 4'hB,
        CL_CALL_ACC = 4'hC, CL_PC_HIGH = 4'hD, CL_BANK = 4'hE, CL_INDIRECT = 4'hF
    } insn_class_t;
    typedef struct packed {
        insn_class_t cls;
        logic [FILE_W-1:0] file_addr;
        logic dest_file;
        logic [BITN_W-1:0] bit_num;
        logic [LIT8_W-1:0] lit8;
        logic [LIT11_W-1:0] lit11;
        logic [LIT7_W-1:0] lit7;
        logic [LIT5_W-1:0] lit5;
        logic ptr_num;
        ptr_mode_t mode;
        logic names_file;
        logic indirect_ref;
    } fields_t;
    // pattern test with don't-care bits masked away
    function automatic logic word_match(input logic [13:0] w, input logic [13:0] p,
                                        input logic [13:0] m);
        word_match = ((w & m) == p);
    endfunction : word_match
endpackage : insn_decode_pkg

// File: quarter_phase_gen.sv
// module: splits the core clock into four quarters per instruction cycle
`timescale 1ns/10ps
module quarter_phase_gen
    import insn_decode_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    output logic [1:0] phase_out,
    output logic cycle_end_out
);
    logic [1:0] phase_q; // current quarter
    logic [1:0] phase_d; // next quarter

    // wraps naturally after the fourth quarter
    assign phase_d = phase_q + CYC_ONE;
    assign phase_out = phase_q;
    assign cycle_end_out = (phase_q == PH_Q4);

    // quarter counter
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            phase_q <= PH_Q1;
        end
        else
        begin
            phase_q <= phase_d;
        end
    end
endmodule : quarter_phase_gen

// File: insn_field_split.sv
// module: splits a 14-bit word into class and operand fields
`timescale 1ns/10ps
module insn_field_split
    import insn_decode_pkg::*;
(
    input wire logic [WORD_W-1:0] word_in,
    output fields_t fields_out
);
    logic grp0; // control group, bits 13 to 7 clear
    logic byte_op; // byte-oriented file op
    logic bit_grp; // bit-oriented group
    logic file_op; // any instruction naming a file register
    insn_class_t cls; // decoded class
    logic [FILE_W-1:0] faddr; // file field

    assign grp0 = word_match(word_in, P_GRP0, M_GRP);
    assign byte_op = word_match(word_in, P_BYTE, M_TOP2) && !grp0;
    assign bit_grp = word_match(word_in, P_BITG, M_TOP2);
    assign file_op = byte_op || bit_grp;
    assign faddr = word_in[FILE_W-1:0];

    // class priority; masked bits never reach a decision
    assign cls = word_match(word_in, P_RET, M_CTL) ? CL_RETURN :
        word_match(word_in, P_IRET, M_CTL) ? CL_RETURN :
        word_match(word_in, P_CALL_VIA_ACCUMULATOR, M_CTL) ? CL_CALL_ACC :
        word_match(word_in, P_ACCBR, M_CTL) ? CL_ACC_BR :
        word_match(word_in, P_IND, M_IND) ? CL_INDIRECT :
        word_match(word_in, P_BANK, M_BANK) ? CL_BANK :
        grp0 ? CL_NOP :
        word_match(word_in, P_DECSK, M_BYTE) ? CL_SKIP_CNT :
        word_match(word_in, P_INCSK, M_BYTE) ? CL_SKIP_CNT :
        byte_op ? CL_BYTE :
        word_match(word_in, P_SKB, M_SKB) ? CL_SKIP_BIT :
        bit_grp ? CL_BIT_OP :
        word_match(word_in, P_CALL, M_SKB) ? CL_CALL :
        word_match(word_in, P_JUMP, M_SKB) ? CL_JUMP :
        word_match(word_in, P_REL, M_REL) ? CL_REL_BR :
        word_match(word_in, P_PCH, M_GRP) ? CL_PC_HIGH :
        word_match(word_in, P_RLIT, M_RLIT) ? CL_RET_LIT : CL_LITERAL;

    // operand fields from fixed places in the word; ptr_num from bit 2 or bit 0 by class
    assign fields_out.cls = cls;
    assign fields_out.file_addr = faddr;
    assign fields_out.dest_file = word_in[DEST_POS];
    assign fields_out.bit_num = word_in[BITN_LSB +: BITN_W];
    assign fields_out.lit8 = word_in[LIT8_W-1:0];
    assign fields_out.lit11 = word_in[LIT11_W-1:0];
    assign fields_out.lit7 = word_in[LIT7_W-1:0];
    assign fields_out.lit5 = word_in[LIT5_W-1:0];
    assign fields_out.ptr_num = (cls == CL_INDIRECT) ? word_in[PTR_POS] : faddr[0];
    assign fields_out.mode = ptr_mode_t'(word_in[MODE_W-1:0]);
    assign fields_out.names_file = file_op;
    assign fields_out.indirect_ref = (cls == CL_INDIRECT) ||
        (file_op && (faddr == IND_REG0 || faddr == IND_REG1));
endmodule : insn_field_split

// File: insn_word_decode_timing.sv
// module: instruction word decoder with cycle timing and operand strobes
`timescale 1ns/10ps
module insn_word_decode_timing
    import insn_decode_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // instruction feed and datapath conditions
    input wire logic [WORD_W-1:0] word_in,
    input wire logic word_valid_in,
    input wire logic skip_cond_in,
    input wire logic [1:0] ptr_prog_in,
    // decoded word and timing
    output logic word_take_out,
    output fields_t fields_out,
    output logic [1:0] phase_out,
    output logic cycle_end_out,
    output logic busy_out,
    // operand strobes
    output logic file_read_out,
    output logic file_write_out,
    output logic acc_write_out,
    output logic ptr_pre_out,
    output logic ptr_post_out,
    // execution progress
    output logic nop_cycle_out,
    output logic insn_done_out,
    output logic [1:0] insn_cycles_out
);
    // execution states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FIRST = 2'b01,
        ST_EXTRA = 2'b10
    } exec_state_t;

    exec_state_t state_q; // current state
    exec_state_t state_d; // next state

    // decoded fields
    fields_t split_w; // fields of the word on the input
    fields_t fields_q; // fields of the executing word

    // cycle accounting
    logic [1:0] base_q; // extra cycles known at decode
    logic [1:0] base_d; // extra cycles from the incoming word
    logic [1:0] left_q; // extra cycles still to run
    logic [1:0] left_d; // next extra count
    logic [1:0] cycles_q; // cycles spent on this word
    logic [1:0] cycles_d; // next spent count

    // timing and decode helpers
    logic [1:0] phase_w; // quarter of the instruction cycle
    logic bound_w; // last quarter of a cycle
    logic fixed_two_w; // class that always costs two cycles
    logic skip_cls_q; // executing word is a conditional skip
    logic ind_prog_w; // indirect operand sits in program memory
    logic [1:0] first_extra_w; // extra cycles fixed at end of first cycle
    logic last_w; // this cycle ends the instruction
    logic free_w; // decoder may accept a new word
    logic take_w; // a word is taken this clock

    // result routing
    logic writes_file_w; // result returns to the file register
    logic writes_acc_w; // result goes to the accumulator
    logic in_first_w; // first cycle of execution

    // quarter generator
    quarter_phase_gen u_phase (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .phase_out(phase_w),
        .cycle_end_out(bound_w)
    );

    // field splitter for the incoming word
    insn_field_split u_split (
        .word_in(word_in),
        .fields_out(split_w)
    );

    // two-cycle classes: calls, returns and program branches
    assign fixed_two_w = (split_w.cls == CL_CALL) || (split_w.cls == CL_CALL_ACC) ||
        (split_w.cls == CL_RETURN) || (split_w.cls == CL_RET_LIT) ||
        (split_w.cls == CL_JUMP) || (split_w.cls == CL_REL_BR) ||
        (split_w.cls == CL_ACC_BR);

    // program-memory pointer adds one cycle to indirect operands
    // pointer space is sampled with the word; a later
    // change does not alter this instruction's length
    assign ind_prog_w = split_w.indirect_ref && ptr_prog_in[split_w.ptr_num];

    // extra cycles known as the word is taken
    assign base_d = (fixed_two_w ? EXTRA_ONE : EXTRA_NONE) +
        (ind_prog_w ? EXTRA_ONE : EXTRA_NONE);

    // a taken skip adds its discard cycle
    // the condition counts only in the last quarter,
    // so a late datapath result is still honoured
    assign first_extra_w = base_q + ((skip_cls_q && skip_cond_in) ? EXTRA_ONE : EXTRA_NONE);

    // end of instruction and acceptance of the next word
    assign in_first_w = (state_q == ST_FIRST);
    assign last_w = bound_w && ((in_first_w && first_extra_w == EXTRA_NONE) ||
        (state_q == ST_EXTRA && left_q == EXTRA_ONE));
    // a free decoder takes only on a boundary
    assign free_w = bound_w && ((state_q == ST_IDLE) || last_w);
    // a take needs a valid word as well
    assign take_w = free_w && word_valid_in;

    // where the result of the executing word goes
    // skip-count words store like byte ops
    assign writes_file_w = (fields_q.cls == CL_BIT_OP) ||
        ((fields_q.cls == CL_BYTE || fields_q.cls == CL_SKIP_CNT) && fields_q.dest_file);
    assign writes_acc_w = ((fields_q.cls == CL_BYTE || fields_q.cls == CL_SKIP_CNT) &&
        !fields_q.dest_file) || (fields_q.cls == CL_LITERAL) || (fields_q.cls == CL_RET_LIT);

    // next state and counters
    always_comb
    begin
        // hold by default
        state_d = state_q;
        left_d = left_q;
        cycles_d = cycles_q;
        if (take_w)
        begin
            // new word starts its first cycle
            state_d = ST_FIRST;
            left_d = EXTRA_NONE;
            cycles_d = CYC_ONE;
        end
        else if (last_w || (free_w && state_q == ST_IDLE))
        begin
            // nothing to take, fall idle
            state_d = ST_IDLE;
            left_d = EXTRA_NONE;
        end
        else if (bound_w && in_first_w)
        begin
            // extra cycles follow the first
            state_d = ST_EXTRA;
            left_d = first_extra_w;
            cycles_d = cycles_q + CYC_ONE;
        end
        else if (bound_w && state_q == ST_EXTRA)
        begin
            // one more extra cycle spent
            left_d = left_q - EXTRA_ONE;
            cycles_d = cycles_q + CYC_ONE;
        end
    end

    // state register
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            // idle with no cycles spent
            state_q <= ST_IDLE;
            left_q <= EXTRA_NONE;
            cycles_q <= EXTRA_NONE;
        end
        else
        begin
            // advance on every clock
            state_q <= state_d;
            left_q <= left_d;
            cycles_q <= cycles_d;
        end
    end

    // decoded word held for the whole execution
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            // no word held
            fields_q <= '0;
            base_q <= EXTRA_NONE;
            skip_cls_q <= 1'b0;
        end
        else if (take_w)
        begin
            // latch the taken word
            fields_q <= split_w;
            base_q <= base_d;
            skip_cls_q <= (split_w.cls == CL_SKIP_BIT) || (split_w.cls == CL_SKIP_CNT);
        end
    end

    // outputs
    assign word_take_out = take_w;
    assign fields_out = fields_q;
    assign phase_out = phase_w;
    assign cycle_end_out = bound_w;
    assign busy_out = (state_q != ST_IDLE);

    // operand strobes, first cycle only
    // read in the second quarter, even for write-only operations
    assign file_read_out = in_first_w && phase_w == PH_Q2 && fields_q.names_file;
    // store in the last quarter, after the read
    assign file_write_out = in_first_w && bound_w && writes_file_w;
    assign acc_write_out = in_first_w && bound_w && writes_acc_w;
    // pointer update before or after the access
    assign ptr_pre_out = in_first_w && phase_w == PH_Q1 &&
        fields_q.cls == CL_INDIRECT && !fields_q.mode[1];
    assign ptr_post_out = in_first_w && bound_w &&
        fields_q.cls == CL_INDIRECT && fields_q.mode[1];

    // extra cycles run as no-ops that drop the fetched word
    assign nop_cycle_out = (state_q == ST_EXTRA);
    assign insn_done_out = last_w;
    assign insn_cycles_out = cycles_q;

    // checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);

    // helper views of the incoming word
    logic [FILE_W-1:0] word_file_w; // file field of the input word
    logic [LIT11_W-1:0] word_lit11_w; // long literal of the input word
    logic plain_one_w; // one-cycle class with no extra
    assign word_file_w = word_in[FILE_W-1:0];
    assign word_lit11_w = word_in[LIT11_W-1:0];
    assign plain_one_w = (split_w.cls == CL_BYTE || split_w.cls == CL_LITERAL) && !ind_prog_w;

    // every instruction cycle is exactly four clocks
    a_cycle_four_quarters: assert property (bound_w |=> !bound_w [*3] ##1 bound_w)
        else $error("instruction cycle is not four clocks");

    // words are only taken on a cycle boundary
    a_take_on_bound: assert property (take_w |-> bound_w)
        else $error("word taken off a cycle boundary");

    // plain byte and literal words finish in one cycle
    a_single_cycle: assert property (take_w && plain_one_w |-> ##4 insn_done_out)
        else $error("plain instruction not done in one cycle");

    // both call forms spend a second cycle
    a_call_two: assert property (take_w && !ind_prog_w &&
        (split_w.cls == CL_CALL || split_w.cls == CL_CALL_ACC)
        |-> ##4 !insn_done_out ##4 insn_done_out)
        else $error("call not two cycles");

    // all returns spend a second cycle
    a_return_two: assert property (take_w && !ind_prog_w &&
        (split_w.cls == CL_RETURN || split_w.cls == CL_RET_LIT)
        |-> ##4 !insn_done_out ##4 insn_done_out)
        else $error("return not two cycles");

    // jumps and branches spend a second cycle
    a_branch_two: assert property (take_w && !ind_prog_w &&
        (split_w.cls == CL_JUMP || split_w.cls == CL_REL_BR || split_w.cls == CL_ACC_BR)
        |-> ##4 !insn_done_out ##4 insn_done_out)
        else $error("branch not two cycles");

    // a taken skip runs one full no-op cycle
    a_skip_discard: assert property (bound_w && in_first_w && skip_cls_q && skip_cond_in &&
        base_q == EXTRA_NONE |=> nop_cycle_out [*4])
        else $error("taken skip lacks a no-op cycle");

    // an untaken skip ends with its first cycle
    a_skip_not_taken: assert property (bound_w && in_first_w && skip_cls_q && !skip_cond_in &&
        base_q == EXTRA_NONE |-> insn_done_out)
        else $error("untaken skip spent a second cycle");

    // program-memory indirect costs one more cycle
    a_indirect_extra: assert property (take_w && ind_prog_w && plain_one_w == 1'b0 &&
        split_w.cls == CL_BYTE |-> ##8 insn_done_out)
        else $error("program-memory indirect lacks extra cycle");

    // a store is always preceded by its read
    a_read_before_write: assert property (file_write_out |-> $past(file_read_out, 2))
        else $error("file write without prior read");

    // operand fields latch from the taken word
    a_file_field: assert property (take_w |=> fields_q.file_addr == $past(word_file_w))
        else $error("file address not latched");
    a_target_field: assert property (take_w |=> fields_q.lit11 == $past(word_lit11_w))
        else $error("jump target not latched");
    a_bank_field: assert property (take_w |=>
        fields_q.lit5 == $past(word_in[LIT5_W-1:0]))
        else $error("bank number not latched");
    a_dest_field: assert property (take_w |=>
        fields_q.dest_file == $past(word_in[DEST_POS]))
        else $error("destination bit not latched");

    // the indirect class names its pointer in its own field
    a_ptr_field: assert property (take_w && split_w.cls == CL_INDIRECT |=>
        fields_q.ptr_num == $past(word_in[PTR_POS]))
        else $error("pointer number not latched");

    // main scenarios reached by the stimulus
    // taken skip
    c_skip_taken: cover property (in_first_w && bound_w && skip_cls_q && skip_cond_in);
    // indirect through program memory
    c_indirect_prog: cover property (take_w && ind_prog_w);
    // back-to-back words
    c_back_to_back: cover property (insn_done_out && take_w);
    // store to a file register
    c_file_write: cover property (file_write_out);
endmodule : insn_word_decode_timing

// File: prog_feed_model.sv
// partner model: program memory feed plus datapath skip and pointer-space inputs
`timescale 1ns/10ps
module prog_feed_model
    import insn_decode_pkg::*;
(
    input wire logic clk_in,
    input wire logic run_in,
    input wire logic take_in,
    input wire logic [6:0] len_in,
    output logic [WORD_W-1:0] word_out,
    output logic valid_out,
    output logic skip_out,
    output logic [1:0] ptr_prog_out
);
    logic [WORD_W-1:0] prog_word [0:127]; // program image, loaded by the bench
    logic prog_skip [0:127]; // skip condition per word
    logic [1:0] prog_ptr [0:127]; // pointer space per word
    logic [6:0] pc = 7'h00; // next word offered
    logic [6:0] exec_idx = 7'h00; // word now executing
    logic taken = 1'b0; // take fired at the last rising edge
    initial
    begin
        word_out = '0;
        valid_out = 1'b0;
        skip_out = 1'b0;
        ptr_prog_out = 2'h0;
    end
    // every change lands at the falling edge, away from the sampling edge
    always @(negedge clk_in)
    begin
        if (taken)
        begin
            exec_idx = pc;
            pc = pc + 7'h01;
        end
        taken = take_in;
        skip_out = prog_skip[exec_idx];
        if (run_in && (pc < len_in))
        begin
            word_out = prog_word[pc];
            ptr_prog_out = prog_ptr[pc];
            valid_out = 1'b1;
        end
        else
        begin
            // nothing offered: toggle so no stale word can pass for a real one
            word_out = ~word_out;
            valid_out = 1'b0;
        end
    end
endmodule : prog_feed_model

// File: insn_word_decode_timing_test.sv
// testbench: random instruction stream checked for class, fields, timing and strobes
`timescale 1ns/10ps
module insn_word_decode_timing_test;
    import insn_decode_pkg::*;
    localparam int N = 64; // words in the program
    localparam int NT = 20; // templates
    typedef struct packed {
        logic [3:0] cls;
        logic [1:0] cyc;
        logic [10:0] key;
        logic [4:0] strb; // read, file write, acc write, pre, post
    } note_t;
    // word templates: fixed opcode bits plus randomised operand bits
    localparam logic [13:0] T_BASE [NT] = '{14'h0700, 14'h0700, 14'h1000, 14'h1800, 14'h1800,
        14'h0B00, 14'h0F00, 14'h3900, 14'h2000, 14'h2800, 14'h0008, 14'h0009, 14'h000A,
        14'h000B, 14'h3400, 14'h3200, 14'h3180, 14'h0020, 14'h0010, 14'h0000};
    localparam logic [13:0] T_MASK [NT] = '{14'h00FF, 14'h0081, 14'h07FF, 14'h07FF, 14'h0381,
        14'h00FF, 14'h00FF, 14'h00FF, 14'h07FF, 14'h07FF, 14'h0000, 14'h0000, 14'h0000,
        14'h0000, 14'h03FF, 14'h01FF, 14'h007F, 14'h001F, 14'h0007, 14'h0000};
    localparam insn_class_t T_CLS [NT] = '{CL_BYTE, CL_BYTE, CL_BIT_OP, CL_SKIP_BIT,
        CL_SKIP_BIT, CL_SKIP_CNT, CL_SKIP_CNT, CL_LITERAL, CL_CALL, CL_JUMP, CL_RETURN,
        CL_RETURN, CL_CALL_ACC, CL_ACC_BR, CL_RET_LIT, CL_REL_BR, CL_PC_HIGH, CL_BANK,
        CL_INDIRECT, CL_NOP};
    logic clk_in; // core clock
    logic rst_b_in; // async reset, active low
    logic run; // partner starts feeding
    logic [WORD_W-1:0] word; // word bus
    logic word_valid, skip_cond, word_take_out, file_read_out, file_write_out;
    logic acc_write_out, ptr_pre_out, ptr_post_out, nop_cycle_out, insn_done_out;
    logic [1:0] ptr_prog; // pointer space bits
    logic busy, cyc_end; // executing flag and cycle boundary
    logic [1:0] phase; // quarter of the cycle
    logic [1:0] insn_cycles_out; // cycles spent
    fields_t fields_out; // decoded fields
    note_t notes[$]; // expected results, oldest first
    note_t nt; // note under comparison
    int err_total = 0;
    int n_tests = 0;
    logic [3:0] span, n_rd, n_fw, n_aw, n_pre, n_post, n_nop; // per-instruction counts
    insn_word_decode_timing insn_word_decode_timing_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .word_in(word), .word_valid_in(word_valid), .skip_cond_in(skip_cond),
        .ptr_prog_in(ptr_prog), .word_take_out(word_take_out), .fields_out(fields_out),
        .phase_out(phase), .cycle_end_out(cyc_end), .busy_out(busy),
        .file_read_out(file_read_out),
        .file_write_out(file_write_out), .acc_write_out(acc_write_out),
        .ptr_pre_out(ptr_pre_out), .ptr_post_out(ptr_post_out), .nop_cycle_out(nop_cycle_out),
        .insn_done_out(insn_done_out), .insn_cycles_out(insn_cycles_out));
    prog_feed_model prog_feed_model_i (.clk_in(clk_in), .run_in(run), .take_in(word_take_out),
        .len_in(7'(N)), .word_out(word), .valid_out(word_valid), .skip_out(skip_cond),
        .ptr_prog_out(ptr_prog));
    // clock at 25 ns
    always #12.5 clk_in = ~clk_in;
    // one comparison, mismatch reported at once
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // operand key from the decoded fields, chosen by class
    function automatic logic [10:0] key_of(input fields_t f);
        case (f.cls)
            CL_BYTE, CL_SKIP_CNT: key_of = 11'({f.dest_file, f.file_addr});
            CL_BIT_OP, CL_SKIP_BIT: key_of = 11'({f.bit_num, f.file_addr});
            CL_LITERAL, CL_RET_LIT: key_of = 11'(f.lit8);
            CL_CALL, CL_JUMP: key_of = f.lit11;
            CL_PC_HIGH: key_of = 11'(f.lit7);
            CL_BANK: key_of = 11'(f.lit5);
            CL_INDIRECT: key_of = 11'({f.ptr_num, f.mode});
            default: key_of = 11'h000;
        endcase
    endfunction : key_of
    // verdict and end of run
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test
    // watcher: counts strobes, compares at every completion
    always @(negedge clk_in)
    begin
        span = span + 4'h1;
        n_rd = n_rd + 4'(file_read_out);
        n_fw = n_fw + 4'(file_write_out);
        n_aw = n_aw + 4'(acc_write_out);
        n_pre = n_pre + 4'(ptr_pre_out);
        n_post = n_post + 4'(ptr_post_out);
        n_nop = n_nop + 4'(nop_cycle_out);
        if (insn_done_out === 1'b1)
        begin
            nt = notes.pop_front();
            check(16'(fields_out.cls), 16'(nt.cls));
            check(16'(key_of(fields_out)), 16'(nt.key));
            check(16'(insn_cycles_out), 16'(nt.cyc));
            check(16'(span), 16'(nt.cyc) * 16'h0004);
            check(16'(n_nop), (16'(nt.cyc) - 16'h0001) * 16'h0004);
            check({n_rd, n_fw, n_aw}, 16'({3'h0, nt.strb[4], 3'h0, nt.strb[3], 3'h0, nt.strb[2]}));
            check({8'h00, n_pre, n_post}, 16'({3'h0, nt.strb[1], 3'h0, nt.strb[0]}));
            check(16'({phase, busy, cyc_end}), 16'h000F);
            {n_rd, n_fw, n_aw, n_pre, n_post, n_nop} = '0;
        end
        if (word_take_out === 1'b1)
            span = 4'h0;
    end
    // watchdog well beyond the longest program
    initial
    begin
        #(25 * 6000);
        err_total++;
        stop_test();
    end
    // program build, reset and run
    initial
    begin
        int t;
        logic [13:0] w;
        logic rd;
        note_t e;
        clk_in = 1'b0;
        rst_b_in = 1'b0;
        run = 1'b0;
        {span, n_rd, n_fw, n_aw, n_pre, n_post, n_nop} = '0;
        void'($urandom(58670));
        for (int i = 0; i < N; i++)
        begin
            t = (i < NT) ? i : int'($urandom_range(NT - 1));
            w = T_BASE[t] | (14'($urandom) & T_MASK[t]);
            prog_feed_model_i.prog_word[i] = w;
            prog_feed_model_i.prog_skip[i] = 1'($urandom);
            prog_feed_model_i.prog_ptr[i] = (T_CLS[t] == CL_INDIRECT) ? 2'h0 : 2'($urandom);
            e.cls = T_CLS[t];
            rd = (t < 7);
            e.cyc = (t > 7 && t < 16) ? 2'h2 : 2'h1;
            if ((e.cls == CL_SKIP_BIT || e.cls == CL_SKIP_CNT) && prog_feed_model_i.prog_skip[i])
                e.cyc = e.cyc + 2'h1;
            if (rd && w[6:1] == 6'h00 && prog_feed_model_i.prog_ptr[i][w[0]])
                e.cyc = e.cyc + 2'h1;
            case (e.cls)
                CL_BYTE, CL_SKIP_CNT: e.key = 11'(w[7:0]);
                CL_BIT_OP, CL_SKIP_BIT: e.key = 11'(w[9:0]);
                CL_LITERAL, CL_RET_LIT: e.key = 11'(w[7:0]);
                CL_CALL, CL_JUMP: e.key = w[10:0];
                CL_PC_HIGH: e.key = 11'(w[6:0]);
                CL_BANK: e.key = 11'(w[4:0]);
                CL_INDIRECT: e.key = 11'(w[2:0]);
                default: e.key = 11'h000;
            endcase
            e.strb[4] = rd;
            e.strb[3] = (e.cls == CL_BIT_OP) || ((t < 2 || t == 5 || t == 6) && w[7]);
            e.strb[2] = ((t < 2 || t == 5 || t == 6) && !w[7]) || t == 7 || t == 14;
            e.strb[1] = (e.cls == CL_INDIRECT) && !w[1];
            e.strb[0] = (e.cls == CL_INDIRECT) && w[1];
            notes.push_back(e);
        end
        repeat (8) @(negedge clk_in);
        rst_b_in = 1'b1;
        run = 1'b1;
        for (int k = 0; k < 3000 && notes.size() != 0; k++)
            @(negedge clk_in);
        repeat (8) @(negedge clk_in);
        check(16'(notes.size()), 16'h0000);
        check(16'(busy), 16'h0000);
        stop_test();
    end
endmodule : insn_word_decode_timing_test
